// ### inc/gcip_cfg.svh
// Constants of the change-detecting port block
`ifndef GCIP_CFG_SVH
`define GCIP_CFG_SVH
`define GCIP_NUM_PORTS 3
`define GCIP_PORT_WIDTH 16
`define GCIP_REG_WIDTH 16
`define GCIP_IEC_IOC_BIT 3
`define GCIP_PAD_CHANGE_DETECT_GLOBAL_ENABLE_BIT 15
`define GCIP_STATUS_RESET 16'h0000
`endif

// ### inc/gcip_pkg.sv
// Types of the change-detecting port block
package gcip_pkg;
    // Per-pin software configuration, one bit of each control register
    typedef struct packed {
        logic analog_select_bits;
        logic direction_bits;
        logic rising_edge_enable;
        logic falling_edge_enable;
        logic weak_pullup_enable;
        logic weak_pulldown_enable;
        logic output_latch_reg;
    } gcip_pin_cfg_t;
endpackage

// ### logic/gcip_port.sv
// General purpose port with per-pin change detection, pulls and analog select
// What this block does
// - Analog-select 1 with direction 1 puts the pin in analog mode.
// - Change detection on a pin needs its rising or falling enable set.
// - Rising enable makes each low-to-high transition raise a change request.
// - Falling enable makes each high-to-low transition raise a change request.
// - Both enables set: a pulse gives two separate change requests.
// - Detection needs interrupt enable bit 3, pad global enable bit 15, irq flag clear.
// - Edge capture must not depend on a running clock in sleep; here pad_in is sampled against prev on clk, so it needs one.
// - A change request sets that pin's change flag.
// - Pin change flag clears only by writing zero; writing one keeps it.
// - Port summary flag sets when any pin flag of the port is set.
// - Port summary flag clears itself once all sixteen pin flags are clear.
// - A new edge during a clearing write leaves the flag set.
// - Each pin has separately enabled weak pull-up and pull-down.
// - Input register reads zero for pins in analog input mode.
// - Direction 1 means input; pins come out of reset as inputs.
`timescale 1ns/10ps
`include "gcip_cfg.svh"

module gcip_port #(
    parameter int NUM_PORTS = `GCIP_NUM_PORTS,
    parameter int PORT_WIDTH = `GCIP_PORT_WIDTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire gcip_pkg::gcip_pin_cfg_t [NUM_PORTS-1:0][PORT_WIDTH-1:0] pin_cfg,
    input wire logic [`GCIP_REG_WIDTH-1:0] interrupt_enable_reg_one,
    input wire logic [`GCIP_REG_WIDTH-1:0] pad_config_reg,
    input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_in,
    input wire logic [NUM_PORTS-1:0] flag_wr,
    input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] flag_wr_data,
    input wire logic [NUM_PORTS-1:0] irq_flag_clr,
    output logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pin_input_reg,
    output logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pin_change_flags,
    output logic [`GCIP_REG_WIDTH-1:0] change_status_reg,
    output logic [NUM_PORTS-1:0] port_change_irq_flag,
    output logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_out,
    output logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_oe,
    output logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_pullup_en,
    output logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_pulldown_en,
    output logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] analog_mode
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] prev;
        logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] flags;
        logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pin_in;
        logic [`GCIP_REG_WIDTH-1:0] status;
        logic [NUM_PORTS-1:0] irq;
        logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_out;
        logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_oe;
        logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pu;
        logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pd;
        logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] analog;
    } gcip_state_t;

    gcip_state_t state_q;
    gcip_state_t state_d;
    logic [NUM_PORTS-1:0] det_ok;
    logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] rise_ev;
    logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] fall_ev;
    logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] clr_mask;
    logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] dig_mask;
    logic enables_ok;
    // Per-port views used only by the checks below
    logic [NUM_PORTS-1:0] any_flag;
    logic [NUM_PORTS-1:0] new_flag;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_d = state_q;
        enables_ok = interrupt_enable_reg_one[`GCIP_IEC_IOC_BIT]
                     & pad_config_reg[`GCIP_PAD_CHANGE_DETECT_GLOBAL_ENABLE_BIT];
        state_d.status = `GCIP_STATUS_RESET;
        for (int p = 0; p < NUM_PORTS; p++) begin
            // A set irq flag blocks new detection on its port
            det_ok[p] = enables_ok & ~state_q.irq[p];
            for (int b = 0; b < PORT_WIDTH; b++) begin
                dig_mask[p][b] = ~pin_cfg[p][b].analog_select_bits;
                // Held level keeps tracking so a re-enable sees no stale edge
                rise_ev[p][b] = det_ok[p] & pin_cfg[p][b].rising_edge_enable
                                & pad_in[p][b] & ~state_q.prev[p][b];
                fall_ev[p][b] = det_ok[p] & pin_cfg[p][b].falling_edge_enable
                                & ~pad_in[p][b] & state_q.prev[p][b];
                clr_mask[p][b] = flag_wr[p] & ~flag_wr_data[p][b];
                state_d.analog[p][b] = pin_cfg[p][b].analog_select_bits
                                       & pin_cfg[p][b].direction_bits;
                state_d.pad_oe[p][b] = ~pin_cfg[p][b].direction_bits
                                       & ~pin_cfg[p][b].analog_select_bits;
                state_d.pad_out[p][b] = pin_cfg[p][b].output_latch_reg;
                state_d.pu[p][b] = pin_cfg[p][b].weak_pullup_enable;
                state_d.pd[p][b] = pin_cfg[p][b].weak_pulldown_enable;
            end
            new_flag[p] = |(rise_ev[p] | fall_ev[p]);
            any_flag[p] = |state_q.flags[p];
            state_d.prev[p] = pad_in[p];
            state_d.pin_in[p] = pad_in[p] & dig_mask[p];
            // Hardware set wins over a clearing write in the same cycle
            state_d.flags[p] = (state_q.flags[p] & ~clr_mask[p])
                               | rise_ev[p] | fall_ev[p];
            state_d.status[p] = |state_d.flags[p];
            state_d.irq[p] = (state_q.irq[p] & ~irq_flag_clr[p])
                             | (state_q.status[p] & enables_ok);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign pin_input_reg = state_q.pin_in;
    assign pin_change_flags = state_q.flags;
    assign change_status_reg = state_q.status;
    assign port_change_irq_flag = state_q.irq;
    assign pad_out = state_q.pad_out;
    assign pad_oe = state_q.pad_oe;
    assign pad_pullup_en = state_q.pu;
    assign pad_pulldown_en = state_q.pd;
    assign analog_mode = state_q.analog;

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_rise;
        rise_ev != '0;
    endsequence

    sequence s_fall;
        fall_ev != '0;
    endsequence

    property p_rise_sets;
        @(posedge clk) disable iff (reset)
        s_rise |=> ((state_q.flags & $past(rise_ev)) == $past(rise_ev));
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("rising edge lost");

    property p_fall_sets;
        @(posedge clk) disable iff (reset)
        s_fall |=> ((state_q.flags & $past(fall_ev)) == $past(fall_ev));
    endproperty
    a_fall_sets: assert property (p_fall_sets) else $error("falling edge lost");

    property p_sticky;
        @(posedge clk) disable iff (reset)
        (flag_wr == '0) |=> ((state_q.flags & $past(state_q.flags)) == $past(state_q.flags));
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

    property p_set_wins;
        @(posedge clk) disable iff (reset)
        ((clr_mask & (rise_ev | fall_ev)) != '0)
        |=> ((state_q.flags & $past(clr_mask & (rise_ev | fall_ev)))
             == $past(clr_mask & (rise_ev | fall_ev)));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat new edge");

    property p_gate;
        @(posedge clk) disable iff (reset)
        (det_ok == '0) |=> ((state_q.flags & ~$past(state_q.flags)) == '0);
    endproperty
    a_gate: assert property (p_gate) else $error("flag set while disabled");

    property p_summary;
        @(posedge clk) disable iff (reset)
        (any_flag & ~change_status_reg[NUM_PORTS-1:0]) == '0;
    endproperty
    a_summary: assert property (p_summary) else $error("summary flag missing");

    property p_summary_clr;
        @(posedge clk) disable iff (reset)
        (~any_flag & change_status_reg[NUM_PORTS-1:0]) == '0;
    endproperty
    a_summary_clr: assert property (p_summary_clr) else $error("summary stuck");

    property p_analog_zero;
        @(posedge clk) disable iff (reset)
        ##1 ((pin_input_reg & ~$past(dig_mask)) == '0);
    endproperty
    a_analog_zero: assert property (p_analog_zero) else $error("analog pin read high");

    property p_reset_input;
        @(posedge clk)
        reset |=> (pad_oe == '0);
    endproperty
    a_reset_input: assert property (p_reset_input) else $error("pin driven after reset");

    property p_irq_cause;
        @(posedge clk) disable iff (reset)
        ((port_change_irq_flag & ~$past(port_change_irq_flag)
          & ~$past(change_status_reg[NUM_PORTS-1:0] & {NUM_PORTS{enables_ok}})) == '0);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");

    property p_irq_blocks;
        @(posedge clk) disable iff (reset)
        (new_flag & port_change_irq_flag) == '0;
    endproperty
    a_irq_blocks: assert property (p_irq_blocks) else $error("edge taken while irq flag set");

    property p_level_quiet;
        @(posedge clk) disable iff (reset)
        (pad_in == state_q.prev) |-> ((rise_ev | fall_ev) == '0);
    endproperty
    a_level_quiet: assert property (p_level_quiet) else $error("edge seen on steady level");

endmodule

// ### sim/gcip_button.sv
// Pin model: push buttons driving the pads, with the pad's weak pulls
`timescale 1ns/10ps
module gcip_button (
    input wire logic [47:0] drv,
    input wire logic [47:0] drv_en,
    input wire logic [47:0] pu,
    input wire logic [47:0] pd,
    output logic [47:0] pad
);
    logic [47:0] last = 48'h0;
    // A floating pin without a pull shows the inverse of its last level, never a stale copy
    always_comb pad = (drv_en & drv) | (~drv_en & pu) | (~drv_en & ~pu & ~pd & ~last);
    always @(drv) last = drv;
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the change-detecting port
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'h0;
    logic reset = 1'h1;
    gcip_pkg::gcip_pin_cfg_t [2:0][15:0] cfg;
    logic [15:0] ie = 16'h0008;
    logic [15:0] pc = 16'h8000;
    logic [15:0] stat;
    logic [2:0][15:0] pad, drv, den, wd, pin, fl, oe, pu, pd, am, po;
    logic [2:0] fw = 3'h0;
    logic [2:0] ic = 3'h0;
    logic [2:0] irq;
    int n_fail = 0;
    int checks_done = 0;
    gcip_port gcip_port_i (.clk(clk), .reset(reset), .pin_cfg(cfg),
        .interrupt_enable_reg_one(ie), .pad_config_reg(pc), .pad_in(pad), .flag_wr(fw),
        .flag_wr_data(wd), .irq_flag_clr(ic), .pin_input_reg(pin), .pin_change_flags(fl),
        .change_status_reg(stat), .port_change_irq_flag(irq), .pad_out(po), .pad_oe(oe),
        .pad_pullup_en(pu), .pad_pulldown_en(pd), .analog_mode(am));
    gcip_button gcip_button_i (.drv(drv), .drv_en(den), .pu(pu), .pd(pd), .pad(pad));
    initial forever #20 clk = ~clk;
    // ****************
    // Helpers
    // ****************
    task automatic tk(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input int p, input logic [15:0] d);
        wd[p] = d;
        fw[p] = 1'h1;
        tk(1);
        fw[p] = 1'h0;
    endtask
    // Pin flags go first, otherwise the port flag re-arms at once
    task automatic clr(input int p);
        wr(p, 16'h0000);
        ic[p] = 1'h1;
        tk(1);
        ic[p] = 1'h0;
        tk(1);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_mode();
        chk("oe after reset", 16'h0000, oe[1]);
        cfg[1][5].analog_select_bits = 1'h1;
        drv[1] = 16'h0060;
        tk(2);
        chk("analog", 16'h0020, am[1]);
        chk("input", 16'h0040, pin[1]);
        cfg[1][5].analog_select_bits = 1'h0;
        cfg[1][5].direction_bits = 1'h0;
        cfg[1][5].output_latch_reg = 1'h1;
        tk(2);
        chk("oe", 16'h0020, oe[1]);
        chk("latch", 16'h0020, po[1]);
        cfg[1][5].direction_bits = 1'h1;
        $display("test mode done");
    endtask
    task automatic t_rise();
        cfg[1][5].rising_edge_enable = 1'h1;
        drv[1] = 16'h0000;
        tk(2);
        chk("fall ignored", 16'h0000, fl[1]);
        drv[1] = 16'h0020;
        tk(1);
        chk("flags", 16'h0020, fl[1]);
        chk("status", 16'h0002, stat);
        tk(1);
        chk("irq", 16'h0002, {13'h0, irq});
        clr(1);
        chk("status clr", 16'h0000, stat);
        chk("irq clr", 16'h0000, {13'h0, irq});
        $display("test rise done");
    endtask
    task automatic t_fall();
        cfg[1][5].rising_edge_enable = 1'h0;
        cfg[1][5].falling_edge_enable = 1'h1;
        pc = 16'h0000;
        drv[1] = 16'h0000;
        tk(2);
        chk("gated", 16'h0000, fl[1]);
        pc = 16'h8000;
        drv[1] = 16'h0020;
        tk(2);
        chk("rise ignored", 16'h0000, fl[1]);
        ie = 16'h0000;
        drv[1] = 16'h0000;
        tk(2);
        chk("gated ie", 16'h0000, fl[1]);
        ie = 16'h0008;
        drv[1] = 16'h0020;
        tk(2);
        drv[1] = 16'h0000;
        tk(1);
        chk("fall", 16'h0020, fl[1]);
        clr(1);
        cfg[1][5].rising_edge_enable = 1'h1;
        drv[1] = 16'h0020;
        tk(1);
        chk("both rise", 16'h0020, fl[1]);
        clr(1);
        drv[1] = 16'h0000;
        tk(1);
        chk("both fall", 16'h0020, fl[1]);
        clr(1);
        $display("test fall done");
    endtask
    task automatic t_race();
        drv[1] = 16'h0020;
        tk(1);
        wr(1, 16'hFFFF);
        chk("write one", 16'h0020, fl[1]);
        pc = 16'h0000;
        ic[1] = 1'h1;
        tk(1);
        ic[1] = 1'h0;
        pc = 16'h8000;
        drv[1] = 16'h0000;
        wr(1, 16'h0000);
        chk("set wins", 16'h0020, fl[1]);
        clr(1);
        $display("test race done");
    endtask
    task automatic t_pull();
        // Pulled pins stay inputs, never digital outputs
        cfg[0][2].weak_pullup_enable = 1'h1;
        cfg[0][3].weak_pulldown_enable = 1'h1;
        den[0] = 16'hFFF3;
        tk(2);
        chk("pullup", 16'h0004, pu[0]);
        chk("pulldown", 16'h0008, pd[0]);
        chk("pulled", 16'h0004, pin[0] & 16'h000C);
        $display("test pull done");
    endtask
    initial begin
        cfg = '0;
        for (int p = 0; p < 3; p++)
            for (int b = 0; b < 16; b++)
                cfg[p][b].direction_bits = 1'h1;
        drv = '0;
        den = '1;
        wd = '0;
        repeat (6) @(negedge clk);
        reset = 1'h0;
        tk(1);
        t_mode();
        t_rise();
        t_fall();
        t_race();
        t_pull();
        tally_and_finish();
    end
    initial begin
        #80000;
        n_fail++;
        tally_and_finish();
    end
endmodule
